/* rtl/csr_defines.svh */
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// Register offsets on the parallel register interface.
`define CSR_OFS_FLAGS      8'h01
`define CSR_OFS_STAT_A     8'h02
`define CSR_OFS_STAT_B     8'h03

// Reset values of the status registers and the read answer for unmapped offsets.
`define CSR_STAT_A_RST     8'h00
`define CSR_STAT_B_RST     8'h00
`define CSR_RDATA_IDLE     8'h00

// First status register bit positions.
`define CSR_A_RSVD_BIT     7
`define CSR_A_VFLOOR_BIT   6
`define CSR_A_ILIM_BIT     5
`define CSR_A_SFLOOR_BIT   4
`define CSR_A_TJREG_BIT    3
`define CSR_A_ZONE_MSB     2
`define CSR_A_ZONE_LSB     0

// Second status register bit positions.
`define CSR_B_CODE_MSB     7
`define CSR_B_CODE_LSB     4
`define CSR_B_SUPPLY_MSB   3
`define CSR_B_SUPPLY_LSB   2
`define CSR_B_CHARGE_BIT   1
`define CSR_B_TSUS_BIT     0

// Battery temperature zone codes.
`define CSR_ZONE_OFF       3'h0
`define CSR_ZONE_COLD      3'h1
`define CSR_ZONE_COOL      3'h2
`define CSR_ZONE_WARM      3'h3
`define CSR_ZONE_HOT       3'h4
`define CSR_ZONE_NORMAL    3'h5

// Charger state codes.
`define CSR_CODE_OFF       4'h0
`define CSR_CODE_PREQUAL   4'h1
`define CSR_CODE_CC        4'h2
`define CSR_CODE_CC_MOD    4'h3
`define CSR_CODE_CV        4'h4
`define CSR_CODE_CV_MOD    4'h5
`define CSR_CODE_TOP       4'h6
`define CSR_CODE_TOP_MOD   4'h7
`define CSR_CODE_DONE      4'h8
`define CSR_CODE_DONE_MOD  4'h9
`define CSR_CODE_PQ_TMO    4'ha
`define CSR_CODE_FC_TMO    4'hb
`define CSR_CODE_TEMP_FLT  4'hc

// Input supply state codes.
`define CSR_SUP_UNDER      2'h0
`define CSR_SUP_OVER       2'h1
`define CSR_SUP_DEBOUNCE   2'h2
`define CSR_SUP_GOOD       2'h3

// Change flag bit positions in the flag register.
`define CSR_FLG_ZONE       0
`define CSR_FLG_CODE       1
`define CSR_FLG_SUPPLY     2
`define CSR_FLG_TJREG      3
`define CSR_FLG_INCTRL     4
`define CSR_FLG_SFLOOR     5
`define CSR_FLG_COUNT      6

`endif

/* rtl/csr_field_sample.sv */
`timescale 1ns/10ps
`default_nettype none

module csr_field_sample #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_r
);

  // Captures a field in one edge so all its bits are seen together.
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= d;
    end
  end

endmodule : csr_field_sample

`default_nettype wire

/* rtl/csr_pkg.sv */
package csr_pkg;

  // Which fast-charge path the charger took most recently, one-hot.
  typedef enum logic [2:0] {
    CSR_PATH_NONE   = 3'b001,
    CSR_PATH_NORMAL = 3'b010,
    CSR_PATH_MOD    = 3'b100
  } csr_path_t;

endpackage : csr_pkg

/* rtl/csr_status_top.sv */
// Behaviour
// - Status A bit 6 shows the input-voltage floor loop engaged.
// - Status A bit 5 shows the input current limit loop engaged.
// - Status A bit 4 shows the system-rail floor loop engaged.
// - Status A bit 3 shows the die temperature loop engaged.
// - Status A bits 2:0 carry the battery temperature zone, codes 0 to 5.
// - Thermistor and charger enabled in cold or hot zone raise temperature fault.
// - Status B bits 7:4 carry the charger state code, off through done.
// - Timer faults report 0xa and 0xb, temperature fault reports 0xc.
// - Done reached through modified fast-charge states reports 0x9.
// - Status B bits 3:2 carry input supply state, four codes.
// - No input power is accepted while supply state is debouncing.
// - Status B bit 1 shows charging in progress.
// - Status B bit 0 shows timer suspended for any of three causes.
// - Status A bit 7 is reserved, reads zero, host writes zero.
// - Changes of state code, supply state or zone set sticky read-cleared flags.
// - Changes of input floor or current limit bits set one shared flag.
`include "csr_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module csr_status_top
  import csr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       input_voltage_floor_active,
  input  wire logic       input_current_limit_active,
  input  wire logic       system_voltage_floor_active,
  input  wire logic       die_temp_regulation_active,
  input  wire logic [2:0] battery_temp_zone,
  input  wire logic [3:0] charger_state_raw,
  input  wire logic [1:0] input_supply_state,
  input  wire logic       charging_now,
  input  wire logic       thermistor_enable,
  input  wire logic       charger_enable,
  input  wire logic       cc_current_below_fifth,
  input  wire logic       supplement_mode,
  output logic            battery_temp_fault,
  output logic            input_power_accept,
  output logic      [5:0] change_flags
);

  logic [3:0]  loops_s;
  logic [2:0]  zone_s;
  logic [3:0]  raw_s;
  logic [1:0]  supply_s;
  logic [3:0]  misc_s;
  logic [7:0]  stat_a_r;
  logic [7:0]  stat_a_nxt;
  logic [7:0]  stat_b_r;
  logic [7:0]  stat_b_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  csr_path_t   path_r;
  csr_path_t   path_nxt;
  logic [3:0]  code_rep;
  logic        timer_sus;
  logic        in_cc;
  logic        raw_done;
  logic        hit_flags;
  logic        hit_a;
  logic        hit_b;
  logic        flag_clr;
  logic [5:0]  flag_evt;
  logic        unused_wr;

  // Sample every status input except charger_enable into the register clock domain.
  csr_field_sample #(.W(4)) u_loops (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({input_voltage_floor_active, input_current_limit_active,
           system_voltage_floor_active, die_temp_regulation_active}),
    .q_r (loops_s)
  );

  csr_field_sample #(.W(3)) u_zone (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (battery_temp_zone),
    .q_r (zone_s)
  );

  csr_field_sample #(.W(4)) u_code (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (charger_state_raw),
    .q_r (raw_s)
  );

  csr_field_sample #(.W(2)) u_supply (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (input_supply_state),
    .q_r (supply_s)
  );

  csr_field_sample #(.W(4)) u_misc (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({charging_now, thermistor_enable, cc_current_below_fifth, supplement_mode}),
    .q_r (misc_s)
  );

  // Battery temperature fault from the enabled thermistor in a cold or hot zone.
  assign battery_temp_fault = misc_s[2] & charger_enable &
                              ((zone_s == `CSR_ZONE_COLD) | (zone_s == `CSR_ZONE_HOT));

  // Tracks whether the last fast-charge state was a temperature-modified one.
  always_comb begin
    case (raw_s)
      `CSR_CODE_CC, `CSR_CODE_CV, `CSR_CODE_TOP:             path_nxt = CSR_PATH_NORMAL;
      `CSR_CODE_CC_MOD, `CSR_CODE_CV_MOD, `CSR_CODE_TOP_MOD: path_nxt = CSR_PATH_MOD;
      `CSR_CODE_OFF, `CSR_CODE_PREQUAL:                      path_nxt = CSR_PATH_NONE;
      default:                                               path_nxt = path_r;
    endcase
  end

  // Path register.
  always_ff @(posedge clk) begin
    if (rst) begin
      path_r <= CSR_PATH_NONE;
    end else if (ce) begin
      path_r <= path_nxt;
    end
  end

  // Reported state code: fault overrides, modified path turns done into its variant.
  assign raw_done = (raw_s == `CSR_CODE_DONE);
  assign code_rep = battery_temp_fault ? `CSR_CODE_TEMP_FLT :
                    (raw_done && path_r == CSR_PATH_MOD) ? `CSR_CODE_DONE_MOD :
                    raw_s;

  // Timer suspend causes: slow current in CC, supplement, temperature fault.
  assign in_cc     = (code_rep == `CSR_CODE_CC) | (code_rep == `CSR_CODE_CC_MOD);
  assign timer_sus = (in_cc & misc_s[1]) | misc_s[0] |
                     (code_rep == `CSR_CODE_TEMP_FLT);

  // Next contents of the first status register; reserved bit forced low.
  assign stat_a_nxt = {1'b0,
                       loops_s[3],
                       loops_s[2],
                       loops_s[1],
                       loops_s[0],
                       zone_s};

  // Next contents of the second status register.
  assign stat_b_nxt = {code_rep,
                       supply_s,
                       misc_s[3],
                       timer_sus};

  // Status registers follow hardware only; host writes never reach them.
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_a_r <= `CSR_STAT_A_RST;
      stat_b_r <= `CSR_STAT_B_RST;
    end else if (ce) begin
      stat_a_r <= stat_a_nxt;
      stat_b_r <= stat_b_nxt;
    end
  end

  // Power is taken from the input only once it is good and debounced.
  assign input_power_accept = (stat_b_r[`CSR_B_SUPPLY_MSB:`CSR_B_SUPPLY_LSB] == `CSR_SUP_GOOD);

  // Field change events feeding the sticky flags.
  assign flag_evt[`CSR_FLG_ZONE]   = stat_a_nxt[`CSR_A_ZONE_MSB:`CSR_A_ZONE_LSB] !=
                                     stat_a_r[`CSR_A_ZONE_MSB:`CSR_A_ZONE_LSB];
  assign flag_evt[`CSR_FLG_CODE]   = stat_b_nxt[`CSR_B_CODE_MSB:`CSR_B_CODE_LSB] !=
                                     stat_b_r[`CSR_B_CODE_MSB:`CSR_B_CODE_LSB];
  assign flag_evt[`CSR_FLG_SUPPLY] = stat_b_nxt[`CSR_B_SUPPLY_MSB:`CSR_B_SUPPLY_LSB] !=
                                     stat_b_r[`CSR_B_SUPPLY_MSB:`CSR_B_SUPPLY_LSB];
  assign flag_evt[`CSR_FLG_TJREG]  = stat_a_nxt[`CSR_A_TJREG_BIT] != stat_a_r[`CSR_A_TJREG_BIT];
  assign flag_evt[`CSR_FLG_INCTRL] =
    (stat_a_nxt[`CSR_A_VFLOOR_BIT] != stat_a_r[`CSR_A_VFLOOR_BIT]) |
    (stat_a_nxt[`CSR_A_ILIM_BIT] != stat_a_r[`CSR_A_ILIM_BIT]);
  assign flag_evt[`CSR_FLG_SFLOOR] = stat_a_nxt[`CSR_A_SFLOOR_BIT] != stat_a_r[`CSR_A_SFLOOR_BIT];

  // Register decode; a read of the flag register clears every flag.
  assign hit_flags = (reg_addr == `CSR_OFS_FLAGS);
  assign hit_a     = (reg_addr == `CSR_OFS_STAT_A);
  assign hit_b     = (reg_addr == `CSR_OFS_STAT_B);
  assign flag_clr  = reg_rd & hit_flags;
  assign unused_wr = reg_wr & (|reg_wdata);

  // One sticky flag per change source.
  genvar gi;
  generate
    for (gi = 0; gi < `CSR_FLG_COUNT; gi++) begin : g_flag
      csr_sticky_flag u_flag (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .set    (flag_evt[gi]),
        .clr    (flag_clr),
        .flag_r (change_flags[gi])
      );
    end
  endgenerate

  // Read data selection; unmapped offsets answer zero.
  assign rdata_nxt = hit_flags ? {2'b00, change_flags} :
                     hit_a     ? stat_a_r :
                     hit_b     ? stat_b_r :
                     `CSR_RDATA_IDLE;

  // Read data register, loaded one edge after the read strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= `CSR_RDATA_IDLE;
    end else if (ce && reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Checks on the status path, the change flags and the read port.
  chk_rsvd_reads_zero: assert property (stat_a_r[`CSR_A_RSVD_BIT] == 1'b0)
    else $error("reserved status bit set");
  chk_vfloor_tracks_in: assert property (
    ce ##1 ce |=> stat_a_r[`CSR_A_VFLOOR_BIT] == $past(input_voltage_floor_active, 2))
    else $error("voltage floor bit wrong");
  chk_ilim_tracks_in: assert property (
    ce ##1 ce |=> stat_a_r[`CSR_A_ILIM_BIT] == $past(input_current_limit_active, 2))
    else $error("current limit bit wrong");
  chk_sfloor_tracks_in: assert property (
    ce ##1 ce |=> stat_a_r[`CSR_A_SFLOOR_BIT] == $past(system_voltage_floor_active, 2))
    else $error("system floor bit wrong");
  chk_tjreg_tracks_in: assert property (
    ce ##1 ce |=> stat_a_r[`CSR_A_TJREG_BIT] == $past(die_temp_regulation_active, 2))
    else $error("die temperature bit wrong");
  chk_zone_tracks_in: assert property (
    ce ##1 ce |=> stat_a_r[`CSR_A_ZONE_MSB:`CSR_A_ZONE_LSB] == $past(battery_temp_zone, 2))
    else $error("zone field wrong");
  chk_fault_cause_zone: assert property (
    battery_temp_fault |-> (zone_s == `CSR_ZONE_COLD || zone_s == `CSR_ZONE_HOT))
    else $error("temperature fault without cold or hot zone");
  chk_fault_code_shown: assert property (
    ce && battery_temp_fault |=> stat_b_r[`CSR_B_CODE_MSB:`CSR_B_CODE_LSB] == `CSR_CODE_TEMP_FLT)
    else $error("temperature fault code missing");
  chk_moddone_code_shown: assert property (
    ce && !battery_temp_fault && raw_done && path_r == CSR_PATH_MOD
    |=> stat_b_r[`CSR_B_CODE_MSB:`CSR_B_CODE_LSB] == `CSR_CODE_DONE_MOD)
    else $error("modified done code missing");
  chk_debounce_no_power: assert property (
    stat_b_r[`CSR_B_SUPPLY_MSB:`CSR_B_SUPPLY_LSB] == `CSR_SUP_DEBOUNCE |-> !input_power_accept)
    else $error("power accepted during debounce");
  chk_charge_tracks_in: assert property (
    ce ##1 ce |=> stat_b_r[`CSR_B_CHARGE_BIT] == $past(charging_now, 2))
    else $error("charging bit wrong");
  chk_supplement_suspends: assert property (
    ce && misc_s[0] |=> stat_b_r[`CSR_B_TSUS_BIT])
    else $error("timer suspend missing in supplement");
  chk_code_change_flags: assert property (
    ce && flag_evt[`CSR_FLG_CODE] |=> change_flags[`CSR_FLG_CODE])
    else $error("state code change not flagged");
  chk_inctrl_shared_flag: assert property (
    ce && (stat_a_nxt[`CSR_A_ILIM_BIT] != stat_a_r[`CSR_A_ILIM_BIT])
    |=> change_flags[`CSR_FLG_INCTRL])
    else $error("input control change not flagged");
  chk_write_no_effect: assert property (
    ce && reg_wr |=> stat_a_r == $past(stat_a_nxt) && stat_b_r == $past(stat_b_nxt))
    else $error("status changed by a host write");
  chk_supply_tracks_in: assert property (
    ce ##1 ce |=> stat_b_r[`CSR_B_SUPPLY_MSB:`CSR_B_SUPPLY_LSB] == $past(input_supply_state, 2))
    else $error("supply state field wrong");
  chk_slow_cc_suspends: assert property (
    ce && in_cc && misc_s[1] |=> stat_b_r[`CSR_B_TSUS_BIT])
    else $error("timer suspend missing on slow constant current");
  chk_zone_change_flags: assert property (
    ce && flag_evt[`CSR_FLG_ZONE] |=> change_flags[`CSR_FLG_ZONE])
    else $error("zone change not flagged");
  chk_supply_change_flags: assert property (
    ce && flag_evt[`CSR_FLG_SUPPLY] |=> change_flags[`CSR_FLG_SUPPLY])
    else $error("supply state change not flagged");
  chk_flag_read_clears: assert property (
    ce && flag_clr && !flag_evt[`CSR_FLG_CODE] |=> !change_flags[`CSR_FLG_CODE])
    else $error("flag not cleared by read");

  cov_flag_read_clear: cover property (ce && flag_clr && |change_flags ##1 change_flags == 6'h00);
  cov_temp_fault: cover property (ce && battery_temp_fault);
  cov_mod_done: cover property (stat_b_r[`CSR_B_CODE_MSB:`CSR_B_CODE_LSB] == `CSR_CODE_DONE_MOD);
  cov_debounce: cover property (stat_b_r[`CSR_B_SUPPLY_MSB:`CSR_B_SUPPLY_LSB] == `CSR_SUP_DEBOUNCE);

endmodule : csr_status_top

`default_nettype wire

/* rtl/csr_sticky_flag.sv */
`timescale 1ns/10ps
`default_nettype none

module csr_sticky_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_r
);

  // Holds an event until cleared; a set in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      flag_r <= set | (flag_r & ~clr);
    end
  end

endmodule : csr_sticky_flag

`default_nettype wire

/* tb/charger_status_reporting_test.sv */
`timescale 1ns/10ps
`default_nettype none

module charger_status_reporting_test;
  import csr_pkg::*;

  // One table row: stimulus beside the register bytes and levels it should give.
  typedef struct packed {
    logic [3:0] lp;
    logic [2:0] zn;
    logic [3:0] raw;
    logic [1:0] sp;
    logic [4:0] mis;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [1:0] eo;
  } csr_row_t;

  logic       clk, rst, ce, reg_rd, reg_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       input_voltage_floor_active, input_current_limit_active;
  logic       system_voltage_floor_active, die_temp_regulation_active;
  logic [2:0] battery_temp_zone;
  logic [3:0] charger_state_raw;
  logic [1:0] input_supply_state;
  logic       charging_now, thermistor_enable, charger_enable;
  logic       cc_current_below_fifth, supplement_mode;
  logic       battery_temp_fault, input_power_accept;
  logic [5:0] change_flags;
  int         num_errors, n_tests;
  csr_row_t   rows [15];

  csr_status_top csr_status_top_inst (
    .clk, .rst, .ce, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .input_voltage_floor_active, .input_current_limit_active,
    .system_voltage_floor_active, .die_temp_regulation_active,
    .battery_temp_zone, .charger_state_raw, .input_supply_state, .charging_now,
    .thermistor_enable, .charger_enable, .cc_current_below_fifth, .supplement_mode,
    .battery_temp_fault, .input_power_accept, .change_flags
  );

  csr_host_model csr_host_model_inst (
    .clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata
  );

  // Free-running 100 MHz clock.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Compares one byte and reports a difference at once.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Drives one set of live status inputs and lets it reach the registers.
  task automatic apply(input csr_row_t r);
    @(posedge clk);
    #1;
    {input_voltage_floor_active, input_current_limit_active} = r.lp[3:2];
    {system_voltage_floor_active, die_temp_regulation_active} = r.lp[1:0];
    battery_temp_zone = r.zn;
    charger_state_raw = r.raw;
    input_supply_state = r.sp;
    {charging_now, thermistor_enable, charger_enable} = r.mis[4:2];
    {cc_current_below_fifth, supplement_mode} = r.mis[1:0];
    repeat (3) @(posedge clk);
    #1;
  endtask : apply

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end

  // Main sequence: table of ordinary cases, then flags, writes, refusals and reset.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    apply('0);
    rows = '{
      {4'h8, 3'h0, 4'h0, 2'h0, 5'h00, 8'h40, 8'h00, 2'h0},
      {4'h4, 3'h1, 4'h1, 2'h1, 5'h08, 8'h21, 8'h14, 2'h0},
      {4'h2, 3'h2, 4'h2, 2'h2, 5'h12, 8'h12, 8'h2b, 2'h0},
      {4'h1, 3'h3, 4'h3, 2'h3, 5'h01, 8'h0b, 8'h3d, 2'h1},
      {4'h0, 3'h5, 4'h4, 2'h3, 5'h0c, 8'h05, 8'h4c, 2'h1},
      {4'h0, 3'h4, 4'h5, 2'h3, 5'h0c, 8'h04, 8'hcd, 2'h3},
      {4'h0, 3'h1, 4'h6, 2'h3, 5'h0c, 8'h01, 8'hcd, 2'h3},
      {4'h0, 3'h5, 4'h6, 2'h3, 5'h1c, 8'h05, 8'h6e, 2'h1},
      {4'h0, 3'h5, 4'h7, 2'h3, 5'h1c, 8'h05, 8'h7e, 2'h1},
      {4'h0, 3'h5, 4'h8, 2'h3, 5'h0c, 8'h05, 8'h9c, 2'h1},
      {4'h0, 3'h5, 4'h0, 2'h3, 5'h0c, 8'h05, 8'h0c, 2'h1},
      {4'h0, 3'h5, 4'h2, 2'h3, 5'h1c, 8'h05, 8'h2e, 2'h1},
      {4'h0, 3'h5, 4'h8, 2'h3, 5'h0c, 8'h05, 8'h8c, 2'h1},
      {4'h0, 3'h5, 4'ha, 2'h3, 5'h0c, 8'h05, 8'hac, 2'h1},
      {4'h0, 3'h5, 4'hb, 2'h3, 5'h0c, 8'h05, 8'hbc, 2'h1}};
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (rows[i]) begin
      apply(rows[i]);
      csr_host_model_inst.rd(8'h02, d);
      chk("status_a", rows[i].ea, d);
      csr_host_model_inst.rd(8'h03, d);
      chk("status_b", rows[i].eb, d);
      chk("zone_valid", {7'h0, rows[i].sp == 2'h3},
          {7'h0, csr_host_model_inst.zone_ok(d)});
      chk("fault_accept", {6'h0, rows[i].eo},
          {6'h0, battery_temp_fault, input_power_accept});
    end
    // Sticky change flags: set by changes, cleared by reading them.
    csr_host_model_inst.rd(8'h01, d);
    csr_host_model_inst.rd(8'h01, d);
    chk("flags_idle", 8'h00, d);
    apply({4'h8, 3'h5, 4'hb, 2'h2, 5'h0c, 18'h0});
    chk("flags_out", 8'h14, {2'h0, change_flags});
    chk("accept_debounce", 8'h00, {7'h0, input_power_accept});
    csr_host_model_inst.rd(8'h01, d);
    chk("flags_read", 8'h14, d);
    csr_host_model_inst.rd(8'h01, d);
    chk("flags_cleared", 8'h00, d);
    apply({4'h6, 3'h5, 4'hb, 2'h2, 5'h0c, 18'h0});
    csr_host_model_inst.rd(8'h01, d);
    chk("flags_loops", 8'h30, d);
    // Writes to the read-only status registers change nothing.
    csr_host_model_inst.wr(8'h02, 8'hff);
    csr_host_model_inst.wr(8'h03, 8'hff);
    csr_host_model_inst.rd(8'h03, d);
    chk("status_b_written", 8'hb8, d);
    csr_host_model_inst.rd(8'h04, d);
    chk("unmapped", 8'h00, d);
    csr_host_model_inst.rd(8'h02, d);
    chk("status_a_written", 8'h35, d);
    // A read offered with the clock enable low is not taken.
    @(posedge clk);
    #1;
    ce = 1'b0;
    csr_host_model_inst.rd(8'h04, d);
    chk("read_frozen", 8'h35, d);
    ce = 1'b1;
    // Reset in mid-run clears the read data and the flags.
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("rdata_reset", 8'h00, reg_rdata);
    chk("flags_reset", 8'h00, {2'h0, change_flags});
    rst = 1'b0;
    repeat (3) @(posedge clk);
    csr_host_model_inst.rd(8'h02, d);
    chk("status_a_after", 8'h35, d);
    // Leaving reset the live fields that differ from zero are flagged once; die temperature stays zero.
    csr_host_model_inst.rd(8'h01, d);
    chk("flags_release", 8'h37, d);
    // Zone, state code and die temperature changes each set their own flag.
    apply({4'h7, 3'h3, 4'h2, 2'h2, 5'h0c, 18'h0});
    csr_host_model_inst.rd(8'h01, d);
    chk("flags_zone_code_tj", 8'h0b, d);
    test_done;
  end
endmodule : charger_status_reporting_test

`default_nettype wire

/* tb/csr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module csr_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // The bus idles with strobes low and no register offset on the address.
  initial begin
    reg_addr  = 8'hff;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end

  // The zone field means something only while the supply state reads good.
  function automatic logic zone_ok(input logic [7:0] b);
    return b[3:2] == 2'h3;
  endfunction : zone_ok

  // One read: the strobe stands across the taking edge, data is picked up after it.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd

  // One write; the reserved top bit of the first status register always goes out as zero.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wr    = 1'b1;
    reg_wdata = (a == 8'h02) ? (v & 8'h7f) : v;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~reg_wdata;
  endtask : wr
endmodule : csr_host_model

`default_nettype wire
